/* File: rtl/tone_sequence_generator.sv */
// tone sequence generator: register file, sequencer and tone output
`timescale 1ns/100ps
`default_nettype none
`include "tone_seq_regs.svh"
// Function
// - single mode plays each position once
// - burst mode repeats sequence repeat-count times
// - repeat count used only in burst mode
// - continuous mode loops until stop
// - step mode plays one tone per send
// - stop ends playback and silences output
// - sequence store holds sixteen symbol indices
// - symbol index fixed, selects one tone
// - standard selection presets frequencies, software overwrites
// - amplitude is percent of generator level
// - tone sounds for position's on time
// - silence for position's off time afterwards
// - pre-emphasis selected or bypassed by setting
// - level off gives zero amplitude

module tone_sequence_generator
    import tone_seq_pkg::*;
#(
    parameter int TICK_CYCLES = `TS_TICK_CYCLES  // cycles per duration tick
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register port
    input  wire logic [9:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // tone parameters to the synthesizer
    output tone_out_t        tone_out
);

    // software settings
    logic [1:0]  mode_q;       // repeat mode
    logic        preemp_q;     // pre-emphasis path select
    logic [7:0]  bursts_q;     // burst repeat count
    logic [7:0]  level_q;      // overall level, zero is off
    logic [4:0]  seq_len_q;    // number of entered positions
    logic [1:0]  std_q;        // selected standard
    // tables
    logic [15:0] freq_q [16];  // frequency per symbol
    logic [6:0]  pct_q  [16];  // relative amplitude per symbol
    logic [3:0]  sym_q  [16];  // symbol per position
    logic [15:0] on_q   [16];  // on ticks per position
    logic [15:0] off_q  [16];  // off ticks per position
    // playback state
    play_st_t    st_q;         // sequencer state
    logic [3:0]  pos_q;        // current position
    logic [15:0] timer_q;      // ticks left in this phase
    logic [15:0] pre_q;        // tick prescaler
    logic [7:0]  left_q;       // bursts left
    // decode and control terms
    region_t     rg;           // region addressed
    logic [3:0]  idx;          // table index
    logic        send_w;       // send command
    logic        stop_w;       // stop command
    logic        start_go;     // send accepted
    logic [3:0]  start_pos;    // position a send starts at
    logic        tick;         // duration tick
    logic        t_end;        // current phase ends
    logic        last;         // current position is the last
    logic [3:0]  cur_sym;      // symbol at current position
    logic [7:0]  amp_w;        // scaled amplitude
    logic [31:0] rd_mux;       // read value

    // region decode used for both writes and reads
    function automatic region_t region_of(input logic [9:0] a);
        case ({a[9:2], 2'b00})
            `TS_CTRL:   region_of = RG_CTRL;
            `TS_CMD:    region_of = RG_CMD;
            `TS_BURSTS: region_of = RG_BURSTS;
            `TS_LEVEL:  region_of = RG_LEVEL;
            `TS_SEQLEN: region_of = RG_SEQLEN;
            `TS_STD:    region_of = RG_STD;
            `TS_STATUS: region_of = RG_STATUS;
            default: begin
                case ({a[9:6], 6'h00})
                    `TS_FREQ_BASE: region_of = RG_FREQ;
                    `TS_AMP_BASE:  region_of = RG_AMP;
                    `TS_SYM_BASE:  region_of = RG_SYM;
                    `TS_ON_BASE:   region_of = RG_ON;
                    `TS_OFF_BASE:  region_of = RG_OFF;
                    default:       region_of = RG_NONE;
                endcase
            end
        endcase
    endfunction

    // preset frequency of a symbol under a standard
    function automatic logic [15:0] preset_freq(input logic [1:0] s,
                                                input logic [3:0] i);
        preset_freq = 16'(`TS_FREQ_BASE_HZ + s * `TS_FREQ_STD_STEP
                          + i * `TS_FREQ_SYM_STEP);
    endfunction

    // command and timing terms
    always_comb begin
        rg        = region_of(reg_addr);
        idx       = reg_addr[5:2];
        send_w    = reg_wr && rg == RG_CMD && reg_wdata[`TS_CMD_SEND];
        stop_w    = reg_wr && rg == RG_CMD && reg_wdata[`TS_CMD_STOP];
        // the repeat count gates a send only in burst mode
        start_go  = send_w && !stop_w && seq_len_q != 5'h00
                    && (mode_q != MODE_BURST || bursts_q != 8'h00)
                    && (mode_q != MODE_STEP || st_q == ST_IDLE);
        // step resumes where it paused, others restart
        start_pos = (mode_q == MODE_STEP && {1'b0, pos_q} < seq_len_q)
                    ? pos_q : 4'h0;
        tick      = pre_q == 16'h0000;
        t_end     = tick && timer_q <= 16'h0001;
        last      = 5'({1'b0, pos_q} + 5'h01) >= seq_len_q;
        cur_sym   = sym_q[pos_q];
    end

    // control registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_q    <= MODE_SINGLE;
            preemp_q  <= 1'b0;
            bursts_q  <= `TS_BURSTS_RST;
            level_q   <= `TS_LEVEL_RST;
            seq_len_q <= 5'h00;
            std_q     <= 2'h0;
        end else if (reg_wr) begin
            case (rg)
                RG_CTRL: begin
                    mode_q   <= reg_wdata[`TS_CTRL_MODE_LSB +: 2];
                    preemp_q <= reg_wdata[`TS_CTRL_PREEMP];
                end
                RG_BURSTS: bursts_q <= reg_wdata[7:0];
                RG_LEVEL:  level_q  <= reg_wdata[7:0];
                RG_SEQLEN: begin
                    // length is frozen during playback, capped at 16
                    if (st_q == ST_IDLE) begin
                        seq_len_q <= (reg_wdata[4:0] > `TS_SEQ_MAX)
                                     ? `TS_SEQ_MAX : reg_wdata[4:0];
                    end
                end
                RG_STD:    std_q    <= reg_wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // symbol definition table, frequencies reloaded on standard selection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int k = 0; k < 16; k++) begin
                freq_q[k] <= preset_freq(2'h0, 4'(k));
                pct_q[k]  <= `TS_PCT_FULL;
            end
        end else if (reg_wr && rg == RG_STD) begin
            for (int k = 0; k < 16; k++) begin
                freq_q[k] <= preset_freq(reg_wdata[1:0], 4'(k));
            end
        end else if (reg_wr && rg == RG_FREQ) begin
            freq_q[idx] <= reg_wdata[15:0];
        end else if (reg_wr && rg == RG_AMP) begin
            pct_q[idx] <= reg_wdata[6:0];
        end
    end

    // sequence store and per-position durations
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int k = 0; k < 16; k++) begin
                sym_q[k] <= 4'(k);
                on_q[k]  <= `TS_ON_RST;
                off_q[k] <= `TS_OFF_RST;
            end
        end else if (reg_wr) begin
            case (rg)
                RG_SYM:  sym_q[idx] <= reg_wdata[3:0];
                RG_ON:   on_q[idx]  <= reg_wdata[15:0];
                RG_OFF:  off_q[idx] <= reg_wdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // tick prescaler, restarted at every phase boundary
    always_ff @(posedge clk_sys) begin
        if (rst || stop_w || start_go || t_end || tick) begin
            pre_q <= 16'(TICK_CYCLES - 1);
        end else begin
            pre_q <= pre_q - 16'h0001;
        end
    end

    // sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q    <= ST_IDLE;
            pos_q   <= 4'h0;
            timer_q <= 16'h0000;
            left_q  <= 8'h00;
        end else if (stop_w) begin
            // stop wins in any mode
            st_q  <= ST_IDLE;
            pos_q <= 4'h0;
        end else if (start_go) begin
            st_q    <= ST_ON;
            pos_q   <= start_pos;
            timer_q <= on_q[start_pos];
            left_q  <= bursts_q;
        end else begin
            case (st_q)
                ST_ON: begin
                    if (t_end) begin
                        // on time over, silence follows
                        st_q    <= ST_OFF;
                        timer_q <= off_q[pos_q];
                    end else if (tick) begin
                        timer_q <= timer_q - 16'h0001;
                    end
                end
                ST_OFF: begin
                    if (!t_end) begin
                        if (tick) begin
                            timer_q <= timer_q - 16'h0001;
                        end
                    end else if (mode_q == MODE_STEP) begin
                        // one tone per send, wrap at the end
                        st_q  <= ST_IDLE;
                        pos_q <= last ? 4'h0 : pos_q + 4'h1;
                    end else if (!last) begin
                        // next entered position
                        st_q    <= ST_ON;
                        pos_q   <= pos_q + 4'h1;
                        timer_q <= on_q[pos_q + 4'h1];
                    end else if (mode_q == MODE_CONT
                                 || (mode_q == MODE_BURST && left_q > 8'h01)) begin
                        // another pass from the first position
                        st_q    <= ST_ON;
                        pos_q   <= 4'h0;
                        timer_q <= on_q[0];
                        left_q  <= left_q - 8'h01;
                    end else begin
                        // single pass or last burst done
                        st_q  <= ST_IDLE;
                        pos_q <= 4'h0;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // amplitude as percent of the generator level
    tone_amp_scale u_scale (
        .level (level_q),
        .pct   (pct_q[cur_sym]),
        .amp   (amp_w)
    );

    // tone output register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tone_out <= '0;
        end else begin
            tone_out.active <= st_q == ST_ON && level_q != 8'h00;
            tone_out.preemp <= preemp_q;
            tone_out.freq   <= freq_q[cur_sym];
            tone_out.amp    <= (st_q == ST_ON) ? amp_w : 8'h00;
        end
    end

    // read value
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (rg)
            RG_CTRL: begin
                rd_mux[`TS_CTRL_MODE_LSB +: 2] = mode_q;
                rd_mux[`TS_CTRL_PREEMP]        = preemp_q;
            end
            RG_BURSTS: rd_mux[7:0]  = bursts_q;
            RG_LEVEL:  rd_mux[7:0]  = level_q;
            RG_SEQLEN: rd_mux[4:0]  = seq_len_q;
            RG_STD:    rd_mux[1:0]  = std_q;
            RG_STATUS: begin
                rd_mux[`TS_ST_ACTIVE]       = st_q == ST_ON;
                rd_mux[`TS_ST_SILENT]       = st_q == ST_OFF;
                rd_mux[`TS_ST_POS_LSB +: 4] = pos_q;
                rd_mux[`TS_ST_LEFT_LSB +: 8] = left_q;
            end
            RG_FREQ:   rd_mux[15:0] = freq_q[idx];
            RG_AMP:    rd_mux[6:0]  = pct_q[idx];
            RG_SYM:    rd_mux[3:0]  = sym_q[idx];
            RG_ON:     rd_mux[15:0] = on_q[idx];
            RG_OFF:    rd_mux[15:0] = off_q[idx];
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= rd_mux;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_pass_end;
        st_q == ST_OFF && t_end && last && !stop_w && !start_go;
    endsequence

    sequence s_restart;
        st_q == ST_ON && pos_q == 4'h0;
    endsequence

    a_stop_silence: assert property (stop_w |=> st_q == ST_IDLE ##1 !tone_out.active)
        else $error("stop did not silence output");
    a_send_restart: assert property (start_go && mode_q != MODE_STEP |=> s_restart)
        else $error("send did not restart at first position");
    a_single_once: assert property (s_pass_end and mode_q == MODE_SINGLE
        |=> st_q == ST_IDLE)
        else $error("single mode did not stop after pass");
    a_burst_again: assert property (s_pass_end and mode_q == MODE_BURST
        && left_q > 8'h01 |=> s_restart and left_q == $past(left_q) - 8'h01)
        else $error("burst pass count wrong");
    a_burst_final: assert property (s_pass_end and mode_q == MODE_BURST
        && left_q <= 8'h01 |=> st_q == ST_IDLE)
        else $error("burst did not stop at count");
    a_cont_loop: assert property (s_pass_end and mode_q == MODE_CONT |=> s_restart)
        else $error("continuous mode did not loop");
    // a send may legally follow the pause at once, so only it may leave idle
    a_step_pause: assert property (st_q == ST_OFF && t_end && !stop_w && !start_go
        && mode_q == MODE_STEP |=> st_q == ST_IDLE ##1 (st_q == ST_IDLE || $past(start_go)))
        else $error("step mode played more than one tone");
    a_on_cause: assert property (tone_out.active |-> $past(st_q) == ST_ON)
        else $error("tone active outside on phase");
    a_off_silent: assert property (st_q == ST_OFF |=> tone_out.amp == 8'h00)
        else $error("tone not silent in off phase");
    a_level_off: assert property (level_q == 8'h00 |=> !tone_out.active)
        else $error("tone active at level off");
    a_pos_bound: assert property (st_q != ST_IDLE |-> {1'b0, pos_q} < seq_len_q)
        else $error("unentered position played");

endmodule
`default_nettype wire

/* File: pkg/tone_seq_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef TONE_SEQ_REGS_SVH
`define TONE_SEQ_REGS_SVH

// scalar registers, byte addresses
`define TS_CTRL        10'h000
`define TS_CMD         10'h004
`define TS_BURSTS      10'h008
`define TS_LEVEL       10'h00C
`define TS_SEQLEN      10'h010
`define TS_STD         10'h014
`define TS_STATUS      10'h018

// tables of sixteen words, indexed by address bits 5:2
`define TS_FREQ_BASE   10'h040
`define TS_AMP_BASE    10'h080
`define TS_SYM_BASE    10'h0C0
`define TS_ON_BASE     10'h100
`define TS_OFF_BASE    10'h140

// control and command fields
`define TS_CTRL_MODE_LSB  0
`define TS_CTRL_PREEMP    2
`define TS_CMD_SEND       0
`define TS_CMD_STOP       1

// status fields
`define TS_ST_ACTIVE      0
`define TS_ST_SILENT      1
`define TS_ST_POS_LSB     4
`define TS_ST_LEFT_LSB    8

// sequence store size
`define TS_SEQ_MAX        5'h10

// reset values
`define TS_PCT_FULL       7'h64
`define TS_ON_RST         16'h0064
`define TS_OFF_RST        16'h0032
`define TS_BURSTS_RST     8'h01
`define TS_LEVEL_RST      8'h00

// preset tone frequencies in Hz: base, per standard, per symbol
`define TS_FREQ_BASE_HZ   1000
`define TS_FREQ_STD_STEP  100
`define TS_FREQ_SYM_STEP  100

// duration tick of 1 ms at a 100 ns clock
`define TS_TICK_NS        1000000
`define TS_CLK_NS         100
`define TS_TICK_CYCLES    (`TS_TICK_NS / `TS_CLK_NS)

`endif

/* File: pkg/tone_seq_pkg.sv */
// types shared by the tone sequence generator files
package tone_seq_pkg;

    // repeat modes as held in the control register
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_BURST  = 2'h1,
        MODE_CONT   = 2'h2,
        MODE_STEP   = 2'h3
    } mode_t;

    // playback states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ON,
        ST_OFF
    } play_st_t;

    // register regions seen by the decoder
    typedef enum logic [3:0] {
        RG_NONE, RG_CTRL, RG_CMD, RG_BURSTS, RG_LEVEL, RG_SEQLEN,
        RG_STD, RG_STATUS, RG_FREQ, RG_AMP, RG_SYM, RG_ON, RG_OFF
    } region_t;

    // tone parameters handed to the synthesizer
    typedef struct packed {
        logic        active;
        logic        preemp;
        logic [15:0] freq;
        logic [7:0]  amp;
    } tone_out_t;

endpackage

/* File: rtl/tone_amp_scale.sv */
// scales the generator level by a symbol's relative amplitude percent
`timescale 1ns/100ps
`default_nettype none
`include "tone_seq_regs.svh"

module tone_amp_scale (
    // level and percent
    input  wire logic [7:0] level,
    input  wire logic [6:0] pct,
    // scaled amplitude
    output logic [7:0]      amp
);

    logic [6:0]  pct_c;  // percent clamped to full scale
    logic [14:0] prod;   // level times percent

    // percentage of the overall level, never above it
    always_comb begin
        pct_c = (pct > `TS_PCT_FULL) ? `TS_PCT_FULL : pct;
        prod  = level * pct_c;
        amp   = 8'(prod / 15'(`TS_PCT_FULL));
    end

endmodule
`default_nettype wire

/* File: bench/tone_synth_model.sv */
// model of the tone synthesizer: measures each tone it is handed
`timescale 1ns/100ps
`default_nettype none
module tone_synth_model
    import tone_seq_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // tone parameters from the generator
    input  wire tone_out_t  tone_out,
    // tone count, noisy silent cycles and measurements of the last tone
    output logic [15:0]     tone_count,
    output logic [15:0]     last_freq,
    output logic [7:0]      last_amp,
    output logic            last_preemp,
    output logic [15:0]     last_len,
    output logic [15:0]     last_gap,
    output logic [15:0]     noisy_off
);
    logic        active_q;  // active one cycle ago
    logic [15:0] run_q;     // length of the current tone or gap

    // time tones and gaps, latch what was heard
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            active_q   <= 1'b0;
            run_q      <= 16'h0000;
            tone_count <= 16'h0000;
            last_len   <= 16'h0000;
            last_gap   <= 16'h0000;
            noisy_off  <= 16'h0000;
        end else begin
            active_q <= tone_out.active;
            run_q    <= (tone_out.active != active_q) ? 16'h0001 : run_q + 16'h0001;
            if (tone_out.active) begin
                last_freq   <= tone_out.freq;
                last_amp    <= tone_out.amp;
                last_preemp <= tone_out.preemp;
            end
            if (tone_out.active && !active_q) begin
                last_gap <= run_q;
            end
            if (!tone_out.active && active_q) begin
                last_len   <= run_q;
                tone_count <= tone_count + 16'h0001;
            end
            // a silent output must carry no amplitude
            if (!tone_out.active && tone_out.amp != 8'h00) begin
                noisy_off <= noisy_off + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/tone_sequence_generator_tb.sv */
// self-checking bench for the tone sequence generator
`timescale 1ns/100ps
`default_nettype none
`include "tone_seq_regs.svh"
module tone_sequence_generator_tb
    import tone_seq_pkg::*;
;
    localparam int TICK = 4;  // shortened duration tick
    logic        clk_sys;
    logic        rst;
    logic [9:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    tone_out_t   tone_out;
    logic [15:0] tone_count, last_freq, last_len, last_gap, noisy_off;
    logic [7:0]  last_amp;
    logic        last_preemp;
    int          fail_count = 0;
    int          checks_done = 0;
    logic [31:0] lfsr = 32'hBBEC;  // random source
    logic [15:0] freq_t [16];      // bench copy of the tables
    logic [6:0]  pct_t [16];
    logic [3:0]  seq_t [16];
    logic [15:0] on_t [16];
    logic [15:0] off_t [16];
    logic [7:0]  level;
    int          nlen;

    tone_sequence_generator #(.TICK_CYCLES(TICK)) tone_sequence_generator_i (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tone_out(tone_out));
    tone_synth_model tone_synth_model_i (
        .clk_sys(clk_sys), .rst(rst), .tone_out(tone_out), .tone_count(tone_count),
        .last_freq(last_freq), .last_amp(last_amp), .last_preemp(last_preemp),
        .last_len(last_len), .last_gap(last_gap), .noisy_off(noisy_off));

    // 10 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        end
        return lfsr;
    endfunction

    // level scaled by a clamped percent, truncating
    function automatic logic [31:0] amp_exp(input logic [6:0] pct);
        logic [31:0] p;
        p = (pct > 7'h64) ? 32'h64 : {25'h0, pct};
        return ({24'h0, level} * p) / 32'h64;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // durations are allowed two cycles of slack
    task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if ($isunknown(got) || got + 32'h2 < exp || got > exp + 32'h2) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    task automatic wait_tone(output logic ok);
        logic [15:0] c0;
        c0 = tone_count;
        ok = 1'b0;
        for (int i = 0; i < 400 && !ok; i++) begin
            @(posedge clk_sys);
            #1;
            ok = (tone_count != c0);
        end
    endtask

    // n tones from position p0, wrapping at the sequence length
    task automatic expect_tones(input int n, input int p0);
        logic ok;
        int   p;
        p = p0;
        for (int i = 0; i < n; i++) begin
            wait_tone(ok);
            chk(ok, 1'b1);
            chk(last_freq, freq_t[seq_t[p]]);
            chk(last_amp, amp_exp(pct_t[seq_t[p]]));
            chk_near(last_len, on_t[p] * TICK);
            if (i > 0) chk_near(last_gap, off_t[(p + nlen - 1) % nlen] * TICK);
            p = (p + 1) % nlen;
        end
    endtask

    task automatic quiet(input int cycles);
        logic [15:0] c0;
        c0 = tone_count;
        repeat (cycles) @(posedge clk_sys);
        #1;
        chk(tone_count, c0);
    endtask

    // random tables and a sequence of n positions
    task automatic setup(input int n);
        nlen  = n;
        level = 8'(rnd() % 255 + 1);
        wr(`TS_LEVEL, {24'h0, level});
        for (int k = 0; k < 16; k++) begin
            freq_t[k] = 16'(rnd() % 3000 + 300);
            pct_t[k]  = 7'(rnd());
            wr(`TS_FREQ_BASE + 10'(4 * k), {16'h0, freq_t[k]});
            wr(`TS_AMP_BASE + 10'(4 * k), {25'h0, pct_t[k]});
        end
        for (int p = 0; p < n; p++) begin
            seq_t[p] = 4'(rnd());
            if (p == 1 && seq_t[1] == seq_t[0]) seq_t[1] = seq_t[0] + 4'h1;
            on_t[p]  = 16'(rnd() % 3 + 1);
            off_t[p] = 16'(rnd() % 3 + 1);
            wr(`TS_SYM_BASE + 10'(4 * p), {28'h0, seq_t[p]});
            wr(`TS_ON_BASE + 10'(4 * p), {16'h0, on_t[p]});
            wr(`TS_OFF_BASE + 10'(4 * p), {16'h0, off_t[p]});
        end
        wr(`TS_SEQLEN, n);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung run
    initial begin
        repeat (30000) @(posedge clk_sys);
        fail_count++;
        $display("watchdog expired");
        final_report();
    end

    // main sequence
    initial begin
        int b;
        rst       = 1'b1;
        reg_addr  = 10'h000;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values of the tables and scalars
        for (int k = 0; k < 16; k++) begin
            rdchk(`TS_FREQ_BASE + 10'(4 * k), 32'(1000 + 100 * k));
            rdchk(`TS_AMP_BASE + 10'(4 * k), 32'h64);
            rdchk(`TS_SYM_BASE + 10'(4 * k), k);
            rdchk(`TS_ON_BASE + 10'(4 * k), 32'h64);
            rdchk(`TS_OFF_BASE + 10'(4 * k), 32'h32);
        end
        rdchk(`TS_CTRL, 32'h0);
        rdchk(`TS_BURSTS, 32'h1);
        rdchk(`TS_LEVEL, 32'h0);
        rdchk(`TS_SEQLEN, 32'h0);
        rdchk(`TS_STATUS, 32'h0);
        wr(10'h3FC, rnd());
        rdchk(10'h3FC, 32'h0);
        // standard change reloads presets, software may then overwrite
        wr(`TS_STD, 32'h2);
        for (int k = 0; k < 16; k++) begin
            rdchk(`TS_FREQ_BASE + 10'(4 * k), 32'(1200 + 100 * k));
        end
        wr(`TS_FREQ_BASE + 10'h00C, 32'h1234);
        rdchk(`TS_FREQ_BASE + 10'h00C, 32'h1234);
        wr(`TS_SEQLEN, 32'h14);
        rdchk(`TS_SEQLEN, 32'h10);
        $display("test registers finished");
        // full store played once, burst count set but unused
        setup(16);
        wr(`TS_BURSTS, 32'h3);
        wr(`TS_CMD, 32'h1);
        expect_tones(16, 0);
        chk(last_preemp, 1'b0);
        quiet(100);
        // a send in mid-play restarts at the first position
        wr(`TS_CMD, 32'h1);
        expect_tones(1, 0);
        wr(`TS_CMD, 32'h1);
        expect_tones(16, 0);
        quiet(100);
        $display("test single finished");
        // burst of b passes
        setup(3);
        b = rnd() % 3 + 2;
        wr(`TS_CTRL, 32'h1);
        wr(`TS_BURSTS, b);
        wr(`TS_CMD, 32'h1);
        expect_tones(3 * b, 0);
        quiet(100);
        $display("test burst finished");
        // step mode, one tone per send
        wr(`TS_CTRL, 32'h3);
        wr(`TS_CMD, 32'h2);
        wr(`TS_CMD, 32'h1);
        expect_tones(1, 0);
        quiet(60);
        // paused at the next position, burst count reloaded by the send
        rdchk(`TS_STATUS, {16'h0, 8'(b), 8'h10});
        wr(`TS_CMD, 32'h1);
        expect_tones(1, 1);
        quiet(60);
        $display("test step finished");
        // continuous until stopped
        wr(`TS_CTRL, 32'h2);
        wr(`TS_CMD, 32'h1);
        expect_tones(7, 0);
        wr(`TS_CMD, 32'h2);
        repeat (3) @(posedge clk_sys);
        #1;
        chk(tone_out.active, 1'b0);
        chk(tone_out.amp, 8'h00);
        quiet(100);
        $display("test continuous finished");
        // pre-emphasis path selected
        wr(`TS_CTRL, 32'h4);
        wr(`TS_CMD, 32'h1);
        expect_tones(1, 0);
        chk(last_preemp, 1'b1);
        wr(`TS_CMD, 32'h2);
        // level off gives no tone at all
        wr(`TS_LEVEL, 32'h0);
        wr(`TS_CTRL, 32'h0);
        wr(`TS_CMD, 32'h1);
        quiet(200);
        chk(noisy_off, 16'h0000);
        $display("test level finished");
        final_report();
    end
endmodule
`default_nettype wire
